// ### design/dsrmu_top.sv
// Decorated store read-modify-write bridge between bus master and slaves
//
// Operation
// RULE1: XOR store reads target, XORs with operand, writes back atomically.
// RULE2: Operand size follows incoming write size: byte, halfword or word.
// RULE3: XOR decoded at peripheral region with opcode 011; low 20 bits offset.
// RULE4: Cycle x forwards address, decodes, turns write into read, captures attributes.
// RULE5: Cycle x+1 issues write address phase from captured address and attributes.
// RULE6: Cycle x+1 data phase registers read XOR write data; master stalled.
// RULE7: Cycle x+2 drives registered result onto slave write data.
// RULE8: Field insert when bit 28 set; LSB from 27:23, width-1 from 22:19.
// RULE9: For field insert bit 19 is width data; offset is bits 18:0.
// RULE10: Software keeps word field width at most 16; code zero is one bit.
// RULE11: Field insert read and write use address masked with E007FFFF.
// RULE12: Mask is width ones shifted by LSB; merge write under mask.
// RULE13: Cycle x+1 selects write data under mask, read data elsewhere; registered.
// RULE14: Master places field at destination bits within its container.
// RULE15: Field past container top inserts only bits that fit.
// RULE16: Master replicates byte and halfword write data on all lanes.
// RULE17: Slave wait states pass to master, extending cycle for cycle.
// RULE18: Undecorated transfers pass unmodified with no added stall.
`timescale 1ns/1ps
`default_nettype none
module dsrmu_top
  import dsrmu_pkg::*;
(
  input  wire logic        clock,     // System bus clock
  input  wire logic        rst,       // Synchronous reset, active high
  input  wire logic [31:0] m_haddr,   // Master address
  input  wire logic [1:0]  m_htrans,  // Master transfer type
  input  wire logic        m_hwrite,  // Master write
  input  wire logic [2:0]  m_hsize,   // Master size
  input  wire logic [31:0] m_hwdata,  // Master write data
  output logic      [31:0] m_hrdata,  // Read data to master
  output logic             m_hready,  // Ready to master
  output logic             m_hresp,   // Response to master
  output logic      [31:0] s_haddr,   // Slave address
  output logic      [1:0]  s_htrans,  // Slave transfer type
  output logic             s_hwrite,  // Slave write
  output logic      [2:0]  s_hsize,   // Slave size
  output logic      [31:0] s_hwdata,  // Slave write data
  input  wire logic [31:0] s_hrdata,  // Slave read data
  input  wire logic        s_hready,  // Slave ready
  input  wire logic        s_hresp    // Slave response
);
  typedef enum logic [1:0] {
    ST_PASS,
    ST_MODIFY,
    ST_WBACK
  } dsrmu_state_t;

  dsrmu_state_t state, next_state;
  dsrmu_op_t    op_q, next_op_q;
  logic [31:0]  addr_q, next_addr_q;
  logic [2:0]   size_q, next_size_q;
  logic [4:0]   lsb_q, next_lsb_q;
  logic [3:0]   wcode_q, next_wcode_q;
  logic [31:0]  result_q, next_result_q;

  dsrmu_op_t    dec_op;
  logic [4:0]   dec_lsb;
  logic [3:0]   dec_wcode;
  logic [31:0]  dec_addr;
  logic [31:0]  mod_mask;
  logic [31:0]  mod_result;
  logic         accept;

  // A write address phase that carries a known decoration
  function automatic logic dsrmu_is_rmw(input logic [1:0] trans, input logic wr, input dsrmu_op_t dop);
    return trans[1] && wr && (dop != DSRMU_OP_NONE);
  endfunction

  dsrmu_decode u_decode (
    .addr      (m_haddr),
    .op        (dec_op),
    .lsb       (dec_lsb),
    .wcode     (dec_wcode),
    .phys_addr (dec_addr)
  );

  dsrmu_modify u_modify (
    .op     (op_q),
    .size   (size_q),
    .lsb    (lsb_q),
    .wcode  (wcode_q),
    .rdata  (s_hrdata),
    .wdata  (m_hwdata),
    .mask   (mod_mask),
    .result (mod_result)
  );

  // A decorated write address phase is taken whenever the bus is not held
  assign accept = (state != ST_MODIFY) && s_hready && dsrmu_is_rmw(m_htrans, m_hwrite, dec_op);

  always_comb begin
    next_state    = state;
    next_op_q     = op_q;
    next_addr_q   = addr_q;
    next_size_q   = size_q;
    next_lsb_q    = lsb_q;
    next_wcode_q  = wcode_q;
    next_result_q = result_q;
    unique case (state)
      ST_MODIFY: begin
        if (s_hready) begin
          next_result_q = mod_result;                          // RULE6 RULE13
          next_state    = ST_WBACK;
        end
      end
      ST_PASS, ST_WBACK: begin
        if (accept) begin
          next_state   = ST_MODIFY;                            // RULE4
          next_op_q    = dec_op;
          next_addr_q  = dec_addr;                             // RULE4 RULE11
          next_size_q  = m_hsize;                              // RULE2
          next_lsb_q   = dec_lsb;
          next_wcode_q = dec_wcode;
        end else if (s_hready) begin
          next_state = ST_PASS;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state    <= ST_PASS;
      op_q     <= DSRMU_OP_NONE;
      addr_q   <= PERIPH_BASE;
      size_q   <= HSIZE_WORD;
      lsb_q    <= 5'h00;
      wcode_q  <= 4'h0;
      result_q <= RESULT_RST;
    end else begin
      state    <= next_state;
      op_q     <= next_op_q;
      addr_q   <= next_addr_q;
      size_q   <= next_size_q;
      lsb_q    <= next_lsb_q;
      wcode_q  <= next_wcode_q;
      result_q <= next_result_q;
    end
  end

  // Bus paths stay combinational so plain transfers see no extra latency
  always_comb begin
    m_hrdata = s_hrdata;
    m_hresp  = s_hresp;
    m_hready = (state == ST_MODIFY) ? 1'b0 : s_hready;         // RULE6 RULE17
    s_hwdata = (state == ST_WBACK) ? result_q : m_hwdata;      // RULE7 RULE18
    if (state == ST_MODIFY) begin
      s_haddr  = addr_q;                                       // RULE5
      s_htrans = HTRANS_NONSEQ;
      s_hwrite = 1'b1;                                         // RULE5
      s_hsize  = size_q;                                       // RULE2
    end else begin
      s_htrans = m_htrans;
      s_hsize  = m_hsize;
      if (dsrmu_is_rmw(m_htrans, m_hwrite, dec_op)) begin
        s_haddr  = dec_addr;                                   // RULE4 RULE11
        s_hwrite = 1'b0;                                       // RULE4
      end else begin
        s_haddr  = m_haddr;                                    // RULE18
        s_hwrite = m_hwrite;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // First address phase: a read at the stripped address
  AST_READ_FIRST: assert property (accept |-> !s_hwrite && s_htrans[1]) // RULE4
    else $error("Decorated store not converted to a read");
  AST_FIELD_ADDR: assert property (accept && dec_op == DSRMU_OP_FIELD // RULE11
    |-> s_haddr == (m_haddr & FIELD_ADDR_MSK))
    else $error("Field insert address not masked");
  AST_XOR_DECODE: assert property (accept && m_haddr[REGION_HI:REGION_LO] == REGION_PERIPH // RULE3
    && !m_haddr[FIELD_OP_BIT] && m_haddr[OPC_HI:OPC_LO] == OPC_XOR
    |-> s_haddr == (PERIPH_BASE | {12'h000, m_haddr[XOR_OFS_HI:0]}))
    else $error("Exclusive-OR store address decoded wrongly");
  AST_READ_PASS: assert property (state != ST_MODIFY && m_htrans[1] && !m_hwrite // RULE18
    |-> s_haddr == m_haddr && !s_hwrite)
    else $error("Read altered by the bridge");

  // Second address phase: a write that reuses the captured attributes
  AST_WRITE_SECOND: assert property (accept |=> s_hwrite && s_htrans == HTRANS_NONSEQ // RULE5
    && s_haddr == $past(s_haddr) && s_hsize == $past(m_hsize))
    else $error("Write-back address phase does not reuse captured attributes");
  AST_XOR_SECOND: assert property (accept && dec_op == DSRMU_OP_XOR // RULE3 RULE5
    |=> s_haddr == (PERIPH_BASE | {12'h000, $past(m_haddr[XOR_OFS_HI:0])}))
    else $error("Exclusive-OR write address not recirculated");
  AST_SIZE_CAPTURE: assert property (accept |=> size_q == $past(m_hsize)) // RULE2
    else $error("Store size not captured");
  AST_FIELD_POS: assert property (accept && dec_op == DSRMU_OP_FIELD // RULE8 RULE9
    |=> lsb_q == $past(m_haddr[LSB_HI:LSB_LO]) && wcode_q == $past(m_haddr[WID_HI:WID_LO]))
    else $error("Field position or width not captured");

  // Modify data phase: master held, merged value registered
  AST_STALL: assert property (accept |=> !m_hready) // RULE6
    else $error("Master not stalled during modify cycle");
  AST_ONE_STALL: assert property (state == ST_MODIFY && s_hready // RULE6 RULE17
    |=> state == ST_WBACK && m_hready == s_hready)
    else $error("Modify cycle not followed by write-back");
  AST_XOR_DATA: assert property (state == ST_MODIFY && s_hready && op_q == DSRMU_OP_XOR // RULE1 RULE7
    |=> state == ST_WBACK && s_hwdata == ($past(s_hrdata) ^ $past(m_hwdata)))
    else $error("Exclusive-OR write-back data wrong");
  AST_FIELD_KEEP: assert property (state == ST_MODIFY && s_hready // RULE12 RULE13 RULE15
    && op_q == DSRMU_OP_FIELD
    |=> ((s_hwdata ^ $past(s_hrdata)) & ~$past(mod_mask)) == 32'h0000_0000
    && ((s_hwdata ^ $past(m_hwdata)) & $past(mod_mask)) == 32'h0000_0000)
    else $error("Field insert merged data wrong");
  AST_FIELD_SINGLE: assert property (state == ST_MODIFY && op_q == DSRMU_OP_FIELD // RULE12
    && size_q == HSIZE_WORD && wcode_q == 4'h0
    |-> mod_mask == (32'h0000_0001 << lsb_q))
    else $error("Single-bit field mask wrong");
  AST_FIELD_WIDTH: assert property (state == ST_MODIFY && op_q == DSRMU_OP_FIELD // RULE12
    && size_q == HSIZE_WORD && lsb_q == 5'h00
    |-> mod_mask == ((32'h0000_0002 << wcode_q) - 32'h0000_0001))
    else $error("Field width mask wrong");
  // A byte mask that spilled past bit 7 would break the lane copies
  AST_FIELD_LANES: assert property (state == ST_MODIFY && op_q == DSRMU_OP_FIELD // RULE2 RULE15
    && size_q == HSIZE_BYTE
    |-> mod_mask[15:8] == mod_mask[7:0] && mod_mask[31:16] == mod_mask[15:0])
    else $error("Byte field mask not kept to one lane");

  // Write-back data phase and slave wait states
  AST_RESULT_HOLD: assert property (state == ST_WBACK && !s_hready // RULE7 RULE17
    |=> state == ST_WBACK && s_hwdata == $past(s_hwdata))
    else $error("Write-back data not held through slave wait");
  AST_WAIT_HOLD: assert property (state == ST_MODIFY && !s_hready // RULE17
    |=> state == ST_MODIFY && !m_hready)
    else $error("Slave wait state not extended to master");
  AST_WAIT_PASS: assert property (state != ST_MODIFY |-> m_hready == s_hready) // RULE17
    else $error("Ready not passed through");

  // Undecorated traffic
  AST_PLAIN: assert property (state == ST_PASS && dec_op == DSRMU_OP_NONE // RULE18
    |-> s_haddr == m_haddr && s_hwrite == m_hwrite && s_hwdata == m_hwdata)
    else $error("Plain transfer altered");
  AST_NO_EXTRA_STALL: assert property (state != ST_MODIFY && !accept |=> state != ST_MODIFY) // RULE18
    else $error("Plain transfer stalled");

  COV_XOR: cover property (accept && dec_op == DSRMU_OP_XOR ##1 s_hready ##1 state == ST_WBACK && s_hready);
  COV_FIELD: cover property (accept && dec_op == DSRMU_OP_FIELD ##1 s_hready ##1 state == ST_WBACK);
  COV_WAIT: cover property (state == ST_MODIFY && !s_hready ##1 s_hready);
  COV_BACK2BACK: cover property (state == ST_WBACK && accept);
endmodule
`default_nettype wire

// ### design/dsrmu_pkg.sv
// Shared constants and types for the decorated store read-modify-write unit
package dsrmu_pkg;
  localparam int          ADDR_W         = 32;
  localparam int          DATA_W         = 32;
  localparam logic [31:0] PERIPH_BASE    = 32'h4000_0000;
  localparam logic [31:0] FIELD_ADDR_MSK = 32'hE007_FFFF;
  localparam int          TOP_BIT        = 31;
  localparam int          REGION_HI      = 30;
  localparam int          REGION_LO      = 29;
  localparam logic [1:0]  REGION_PERIPH  = 2'h2;
  localparam int          OPC_HI         = 28;
  localparam int          OPC_LO         = 26;
  localparam logic [2:0]  OPC_XOR        = 3'h3;
  localparam int          FIELD_OP_BIT   = 28;
  localparam int          LSB_HI         = 27;
  localparam int          LSB_LO         = 23;
  localparam int          WID_HI         = 22;
  localparam int          WID_LO         = 19;
  localparam int          XOR_OFS_HI     = 19;
  localparam logic [1:0]  HTRANS_IDLE    = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_BYTE     = 3'h0;
  localparam logic [2:0]  HSIZE_HALF     = 3'h1;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic [31:0] RESULT_RST     = 32'h0000_0000;

  typedef enum logic [1:0] {
    DSRMU_OP_NONE,
    DSRMU_OP_XOR,
    DSRMU_OP_FIELD
  } dsrmu_op_t;
endpackage

// ### design/dsrmu_decode.sv
// Address decoration decoder: operation, field position and real address
`timescale 1ns/1ps
`default_nettype none
module dsrmu_decode
  import dsrmu_pkg::*;
(
  input  wire logic [31:0] addr,      // Decorated address from master
  output dsrmu_op_t        op,        // Decoded store operation
  output logic      [4:0]  lsb,       // Field LSB position
  output logic      [3:0]  wcode,     // Field width minus one
  output logic      [31:0] phys_addr  // Address with decoration removed
);
  always_comb begin
    op        = DSRMU_OP_NONE;
    phys_addr = addr;
    lsb       = addr[LSB_HI:LSB_LO];                           // RULE8
    wcode     = addr[WID_HI:WID_LO];                           // RULE8
    if (!addr[TOP_BIT] && addr[REGION_HI:REGION_LO] == REGION_PERIPH) begin
      if (addr[FIELD_OP_BIT]) begin
        op        = DSRMU_OP_FIELD;                            // RULE8
        phys_addr = addr & FIELD_ADDR_MSK;                     // RULE9 RULE11
      end else if (addr[OPC_HI:OPC_LO] == OPC_XOR) begin
        op        = DSRMU_OP_XOR;                              // RULE3
        phys_addr = PERIPH_BASE | {12'h000, addr[XOR_OFS_HI:0]}; // RULE3
      end
    end
  end
endmodule
`default_nettype wire

// ### design/dsrmu_modify.sv
// Modify stage: exclusive-OR or masked field insert of read data
`timescale 1ns/1ps
`default_nettype none
module dsrmu_modify
  import dsrmu_pkg::*;
(
  input  wire dsrmu_op_t   op,     // Operation being performed
  input  wire logic [2:0]  size,   // Transfer size of the store
  input  wire logic [4:0]  lsb,    // Field LSB position
  input  wire logic [3:0]  wcode,  // Field width minus one
  input  wire logic [31:0] rdata,  // Memory read data
  input  wire logic [31:0] wdata,  // Store write operand
  output logic      [31:0] mask,   // Lane-replicated field mask
  output logic      [31:0] result  // Value to write back
);
  logic [16:0] ones;
  logic [47:0] wide;

  always_comb begin
    // Width is at most sixteen, so seventeen bits of ones cover it
    ones = 17'h1FFFF >> (5'h10 - {1'b0, wcode});               // RULE12
    wide = {31'h0000_0000, ones} << lsb;                       // RULE12
    // Truncating to the container drops bits past its top edge
    unique case (size)
      HSIZE_BYTE: mask = {4{wide[7:0]}};                       // RULE15
      HSIZE_HALF: mask = {2{wide[15:0]}};                      // RULE15
      default:    mask = wide[31:0];
    endcase
    if (op == DSRMU_OP_FIELD) begin
      result = (rdata & ~mask) | (wdata & mask);               // RULE13
    end else begin
      result = rdata ^ wdata;                                  // RULE1 RULE6
    end
  end
endmodule
`default_nettype wire

// ### test/dsrmu_slave_model.sv
// Peripheral-side bus slave model: word memory with programmable wait states
`timescale 1ns/1ps
`default_nettype none
module dsrmu_slave_model (
  input  wire logic [0:0]  clock,   // Bus clock
  input  wire logic        rst,     // Synchronous reset
  input  wire logic [31:0] haddr,   // Address
  input  wire logic [1:0]  htrans,  // Transfer type
  input  wire logic        hwrite,  // Write
  input  wire logic [2:0]  hsize,   // Size
  input  wire logic [31:0] hwdata,  // Write data
  input  wire logic [3:0]  waits,   // Wait states per transfer
  output logic      [31:0] hrdata,  // Read data
  output logic             hready,  // Ready
  output logic             hresp    // Response, always okay
);
  logic [31:0] mem [16];
  logic [31:0] last;
  logic [31:0] lm;
  logic [3:0]  idx;
  logic [3:0]  cnt;
  logic        act;
  logic        wr;
  assign hresp = 1'b0;
  // Outside a read data phase show the inverse of the last value, so stale data never matches
  assign hrdata = (act && !wr && hready) ? mem[idx] : ~last;
  always_ff @(posedge clock) begin
    if (rst) begin
      hready <= 1'b1;
      act    <= 1'b0;
      last   <= 32'h0000_0000;
    end else if (act && !hready) begin
      cnt    <= cnt - 4'h1;
      hready <= (cnt == 4'h1);
    end else begin
      if (act && wr)
        mem[idx] <= (mem[idx] & ~lm) | (hwdata & lm);
      if (act && !wr)
        last <= mem[idx];
      act    <= htrans[1];
      wr     <= hwrite;
      idx    <= haddr[5:2];
      lm     <= (hsize == 3'h0) ? 32'h0000_00FF << {haddr[1:0], 3'h0} :
                (hsize == 3'h1) ? 32'h0000_FFFF << {haddr[1], 4'h0} : 32'hFFFF_FFFF;
      cnt    <= waits;
      hready <= !(htrans[1] && waits != 4'h0);
    end
  end
endmodule
`default_nettype wire

// ### test/dsrmu_top_tb.sv
// Bench for the decorated store bridge: plain, XOR, field insert and pass-through stores
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module dsrmu_top_tb;
  import dsrmu_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] m; logic [2:0] s;} dsrmu_note_t;
  logic        clock, rst, m_hwrite, m_hready, m_hresp, s_hwrite, s_hready, s_hresp, dph;
  logic [1:0]  m_htrans, s_htrans, ln;
  logic [2:0]  m_hsize, s_hsize, sz, dph_s;
  logic [3:0]  waits, wc;
  logic [4:0]  b;
  logic [31:0] m_haddr, m_hwdata, m_hrdata, s_haddr, s_hwdata, s_hrdata, dph_a, rd, v, d, wd;
  logic [31:0] shadow [16];
  dsrmu_note_t notes [$];
  dsrmu_note_t n;
  int          fails = 0, compares = 0, tick = 0, seed, i;
  dsrmu_top i_dsrmu_top (.clock(clock), .rst(rst), .m_haddr(m_haddr), .m_htrans(m_htrans), .m_hwrite(m_hwrite),
    .m_hsize(m_hsize), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready), .m_hresp(m_hresp),
    .s_haddr(s_haddr), .s_htrans(s_htrans), .s_hwrite(s_hwrite), .s_hsize(s_hsize), .s_hwdata(s_hwdata),
    .s_hrdata(s_hrdata), .s_hready(s_hready), .s_hresp(s_hresp));
  dsrmu_slave_model i_dsrmu_slave_model (.clock(clock), .rst(rst), .haddr(s_haddr), .htrans(s_htrans),
    .hwrite(s_hwrite), .hsize(s_hsize), .hwdata(s_hwdata), .waits(waits), .hrdata(s_hrdata),
    .hready(s_hready), .hresp(s_hresp));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    tick++;
    if (tick == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  // Scoreboard: each completed slave write data phase takes the oldest note
  always @(posedge clock) begin
    if (dph && s_hready === 1'b1) begin
      n = notes.pop_front();
      `CHK("slave address", n.a, dph_a)
      `CHK("slave size", n.s, dph_s)
      `CHK("slave write data", n.d & n.m, s_hwdata & n.m)
    end
    if (rst) begin
      dph <= 1'b0;
    end else if (s_hready === 1'b1) begin
      dph <= (s_htrans[1] === 1'b1) && (s_hwrite === 1'b1);
      dph_a <= s_haddr;
      dph_s <= s_hsize;
    end
  end
  task automatic xfer(input logic [31:0] a, input logic [2:0] tsz, input logic wr, input logic [31:0] twd,
                      input int ecyc);
    int   cyc;
    logic rdy;
    @(negedge clock);
    m_haddr = a;
    m_htrans = HTRANS_NONSEQ;
    m_hwrite = wr;
    m_hsize = tsz;
    @(negedge clock);
    m_htrans = HTRANS_IDLE;
    m_hwdata = twd;
    cyc = 0;
    rdy = 1'b0;
    while (rdy !== 1'b1 && cyc < 40) begin
      if (cyc > 0)
        @(negedge clock);
      #1;
      cyc++;
      rdy = m_hready;
      rd = m_hrdata;
    end
    `CHK("stall cycles", ecyc, cyc)
    `CHK("response", 1'b0, m_hresp)
    @(posedge clock);
  endtask
  // Kind 0 plain, 1 exclusive-OR, 2 field insert, 3 undecoded opcode
  task automatic store(input int kind, input logic [3:0] idx);
    logic [31:0] a, ea, cm, fm, nw, off;
    logic [4:0]  sh;
    logic [63:0] f64;
    off = {26'h0, idx, ln};
    sh = (sz == HSIZE_BYTE) ? {ln, 3'h0} : (sz == HSIZE_HALF) ? {ln[1], 4'h0} : 5'h00;
    cm = (sz == HSIZE_BYTE) ? 32'h0000_00FF : (sz == HSIZE_HALF) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    f64 = ((64'h1 << (wc + 5'h01)) - 64'h1) << b;
    fm = (f64[31:0] & cm) << sh;
    a = (kind == 1) ? 32'h4C00_0000 | off : (kind == 3) ? 32'h4400_0000 | off : PERIPH_BASE | off;
    if (kind == 2)
      a = 32'h5000_0000 | {4'h0, b, wc, 19'h0} | off;
    ea = (kind == 2) ? (a & 32'hE007_FFFF) : (kind == 1) ? (PERIPH_BASE | off) : a;
    nw = (kind == 1) ? shadow[idx] ^ wd : (kind == 2) ? (shadow[idx] & ~fm) | (wd & fm) : wd;
    notes.push_back('{ea, nw, cm << sh, sz});
    shadow[idx] = (shadow[idx] & ~(cm << sh)) | (nw & (cm << sh));
    xfer(a, sz, 1'b1, wd, (kind == 1 || kind == 2) ? 2 + 2 * waits : 1 + waits);
  endtask
  initial begin
    seed = 84997;
    rst = 1'b1;
    m_haddr = 32'h0000_0000;
    m_htrans = HTRANS_IDLE;
    m_hwrite = 1'b0;
    m_hsize = HSIZE_WORD;
    m_hwdata = 32'h0000_0000;
    waits = 4'h0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    sz = HSIZE_WORD;
    ln = 2'h0;
    for (i = 0; i < 4; i++) begin
      wd = $random(seed);
      store(0, i[3:0]);
    end
    $display("plain stores done");
    for (i = 0; i < 27; i++) begin
      @(negedge clock);
      waits = 4'(i % 3);
      sz = 3'((i / 3) % 3);
      v = $random(seed);
      d = $random(seed);
      ln = v[3:2] & ((sz == HSIZE_BYTE) ? 2'h3 : (sz == HSIZE_HALF) ? 2'h2 : 2'h0);
      wd = (sz == HSIZE_BYTE) ? {4{d[7:0]}} : (sz == HSIZE_HALF) ? {2{d[15:0]}} : d;
      b = (i % 9 == 7) ? 5'h00 : v[8:4] & ((sz == HSIZE_BYTE) ? 5'h07 : (sz == HSIZE_HALF) ? 5'h0F : 5'h1F);
      wc = (i % 3 == 0) ? 4'h0 : v[12:9];
      store(1, {2'h0, v[1:0]});
      store(2, {2'h0, v[1:0]});
      store(3, {2'h0, v[1:0]});
      xfer(PERIPH_BASE | {26'h0, 2'h0, v[1:0], 2'h0}, HSIZE_WORD, 1'b0, 32'h0000_0000, 1 + waits);
      `CHK("read back", shadow[{2'h0, v[1:0]}], rd)
    end
    $display("decorated stores done");
    `CHK("notes left", 0, notes.size())
    report_and_stop();
  end
endmodule
`default_nettype wire
